// ### cpu_defs_regs.svh
// register offsets, field positions, reset values, opcodes and cycle counts of the decode core
`ifndef CPU_DEFS_REGS_SVH
`define CPU_DEFS_REGS_SVH

// register byte offsets on the bus (word aligned)
`define OFF_CTRL 8'h00
`define OFF_ROWPTR 8'h04
`define OFF_CONFIG 8'h08
`define OFF_ADDRREG 8'h0C
`define OFF_STATUS 8'h10
`define OFF_DBUF 8'h14
`define OFF_CTX 8'h18

// control register bits
`define CTRL_RUN 0
`define CTRL_PTR_EN 1
`define CTRL_CFLAG 2
// config register fields: bank in [3:0], general register row in [6:4]
`define CFG_BANK_LSB 0
`define CFG_ROW_LSB 4
// status register fields, and the saved context field of the context register
`define STAT_SP_LSB 16
`define STAT_SKIP 24
`define STAT_INT_PEND 25
`define CTX_SAVE_LSB 8

// reset values
`define CTRL_RST 3'h0
`define ROWPTR_RST 7'h00
`define BANK_RST 4'h0
`define GROW_RST 3'h0
`define PC_RST 11'h000
`define AREG_RST 11'h000

// major opcodes, bits 15..11 of the instruction word
`define OP_BIT_TRUE 5'h1E
`define OP_BIT_FALSE 5'h1F
`define OP_SKIP_EQ 5'h09
`define OP_SKIP_NE 5'h0B
`define OP_SKIP_GE 5'h19
`define OP_SKIP_LT 5'h1B
`define OP_MOV_ST 5'h0A
`define OP_MOV_LD 5'h1A
`define OP_CALL 5'h1C
`define OP_SYS 5'h07

// system group sub-codes in bits 7..4, and the return kinds in bits 10..8
`define SUB_TABLE 4'h1
`define SUB_CALL_REG 4'h5
`define SUB_POP 4'hC
`define SUB_PUSH 4'hD
`define SUB_RET 4'hE
`define RET_PLAIN 3'h0
`define RET_SKIP 3'h1
`define RET_INT 3'h4

// instruction cycles taken by the table read
`define TABLE_CYCLES 2

`endif

// ### cpu_pkg.sv
// types shared by the decode core, the memory model and the bench
package cpu_pkg;
	// one-hot sequencer states
	typedef enum logic [5:0] {
		S_FETCH = 6'h01,
		S_DECODE = 6'h02,
		S_READM = 6'h04,
		S_READR = 6'h08,
		S_READS = 6'h10,
		S_TABLE = 6'h20
	} core_state_t;

	// data memory request: address is {bank, row, column}
	typedef struct packed {
		logic [10:0] addr;
		logic [3:0] wdata;
		logic we;
	} dm_req_t;

	// instruction word fields
	typedef struct packed {
		logic [4:0] op;
		logic [2:0] mr;
		logic [3:0] mc;
		logic [3:0] n;
	} instr_t;
endpackage

// ### addr_stack.sv
// address stack: flip-flop entries, one write port, one combinational read port
`timescale 1ns/1ps
module addr_stack #(
	parameter int SP_W = 3,
	parameter int DATA_W = 11
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [SP_W-1:0] wr_idx,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [SP_W-1:0] rd_idx,
	output logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] entry_q [2**SP_W];

	// one process per entry so each flop has a single write decode
	for (genvar i = 0; i < 2**SP_W; i++) begin : g_entry
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				entry_q[i] <= '0;
			end else if (ce && wr_en && wr_idx == SP_W'(i)) begin
				entry_q[i] <= wr_data;
			end
		end
	end

	// read is combinational so pop and return finish in one cycle
	assign rd_data = entry_q[rd_idx];
endmodule

// ### decode_core.sv
// test, compare, indirect move, table read, stack and call/return decode core with AHB-Lite registers
// What this block does
// - bit-test-true clears compare flag, skips when memory AND mask equals mask.
// - bit-test-false clears compare flag, skips when memory AND mask is zero.
// - skip-if-equal subtracts immediate, skips on zero difference, stores nothing.
// - skip-if-not-equal subtracts immediate, skips on nonzero difference.
// - skip-if-greater-equal subtracts immediate, skips when no borrow.
// - skip-if-less-than subtracts immediate, skips on borrow.
// - indirect store writes memory nibble to pointer-formed or bank-formed address.
// - indirect load reads nibble from the same address form into operand.
// - table read saves counter, fetches word at address register, restores counter.
// - table read and indirect store take four clocks, indirect load five, others three, a skipped word two.
// - push decrements stack pointer, then writes address register to stack.
// - pop loads address register from stack, then increments stack pointer.
// - call pushes counter, loads counter from immediate or address register.
// - returns reload counter from stack, bump pointer; skip variant skips once.
// - interrupt return reloads counter, restores saved context, bumps pointer.
// - immediate call targets are 11 bits with top bit zero.
// - pointer enable flag chooses whether row pointer forms indirect addresses.
// - interrupt entry saves context to interrupt stack register.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cpu_defs_regs.svh"
module decode_core #(
	parameter int SP_W = 3,
	parameter int CTX_W = 8,
	parameter logic [10:0] INT_VECTOR = 11'h001
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic int_entry,
	output logic [10:0] pm_addr,
	input wire logic [15:0] pm_data,
	output cpu_pkg::dm_req_t dm_req,
	input wire logic [3:0] dm_rdata
);
	import cpu_pkg::*;

	core_state_t st_q, st_d;
	instr_t ir_q, pm_word;
	dm_req_t dm_q, dm_d;
	logic [10:0] pc_q, pc_d, pm_addr_q, pm_d, areg_q, stk_rdata, stk_wdata, call_tgt;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [3:0] mval_q, bank_q;
	logic [2:0] grow_q;
	logic [6:0] rowptr_q;
	logic [15:0] tbuf_q;
	logic [CTX_W-1:0] ctx_q, ctx_save_q;
	logic run_q, ptr_en_q, cflag_q, skip_q, skip_d, int_pend_q;
	logic cflag_clr, areg_ld, tbuf_ld, ctx_rest, int_take, stk_we;
	logic hit_true, hit_false, diff_zero, borrow;
	logic [4:0] diff;
	logic hreadyout_q, hresp_q, wr_pend_q, rd_take, wr_take;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q, rd_val, wval;

	assign pm_word = instr_t'(pm_data);
	assign call_tgt = {1'b0, ir_q.mr[1:0], ir_q.mc, ir_q.n}; // top bit forced low

	// operand address {bank, row, column}
	function automatic logic [10:0] m_addr(input instr_t i);
		return {bank_q, i.mr, i.mc};
	endfunction

	// indirect address: row pointer or {bank, operand row}, then register content
	function automatic logic [10:0] ind_addr(input logic [3:0] rval);
		return ptr_en_q ? {rowptr_q, rval} : {bank_q, ir_q.mr, rval};
	endfunction

	// write strobe for one register in the data phase
	function automatic logic wr_hit(input logic [7:0] off);
		return wr_pend_q && wr_addr_q == off;
	endfunction

	// test and compare terms on the operand nibble read this cycle
	assign hit_true = (dm_rdata & ir_q.n) == ir_q.n;
	assign hit_false = (dm_rdata & ir_q.n) == 4'h0;
	assign diff = {1'b0, dm_rdata} - {1'b0, ir_q.n};
	assign diff_zero = diff[3:0] == 4'h0;
	assign borrow = diff[4];

	addr_stack #(.SP_W(SP_W), .DATA_W(11)) u_stack (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_en(stk_we),
		.wr_idx(sp_d),
		.wr_data(stk_wdata),
		.rd_idx(sp_q),
		.rd_data(stk_rdata)
	);

	// sequencer: one instruction per pass; table read and indirect store add one state after S_READM, indirect load two
	always_comb begin
		st_d = st_q;
		pc_d = pc_q;
		sp_d = sp_q;
		skip_d = skip_q;
		pm_d = pm_addr_q;
		dm_d = dm_q;
		dm_d.we = 1'b0;
		cflag_clr = 1'b0;
		areg_ld = 1'b0;
		tbuf_ld = 1'b0;
		ctx_rest = 1'b0;
		int_take = 1'b0;
		stk_we = 1'b0;
		stk_wdata = pc_q;
		case (st_q)
			S_FETCH: begin
				if (run_q && int_pend_q) begin
					// interrupt entry pushes the counter and jumps to the vector
					int_take = 1'b1;
					sp_d = sp_q - SP_W'(1);
					stk_we = 1'b1;
					pc_d = INT_VECTOR;
				end else if (run_q) begin
					pm_d = pc_q;
					st_d = S_DECODE;
				end
			end
			S_DECODE: begin
				pc_d = pc_q + 11'h001;
				if (skip_q) begin
					skip_d = 1'b0; // fetched word dropped: counter advances and ir_q loads, no memory access
					st_d = S_FETCH;
				end else begin
					dm_d.addr = m_addr(pm_word);
					st_d = S_READM;
				end
			end
			S_READM: begin
				st_d = S_FETCH;
				case (ir_q.op)
					`OP_BIT_TRUE: begin
						cflag_clr = 1'b1;
						skip_d = hit_true;
					end
					`OP_BIT_FALSE: begin
						cflag_clr = 1'b1;
						skip_d = hit_false;
					end
					`OP_SKIP_EQ: skip_d = diff_zero;
					`OP_SKIP_NE: skip_d = !diff_zero;
					`OP_SKIP_GE: skip_d = !borrow;
					`OP_SKIP_LT: skip_d = borrow;
					`OP_MOV_ST, `OP_MOV_LD: begin
						dm_d.addr = {bank_q, grow_q, ir_q.n}; // fetch general register content
						st_d = S_READR;
					end
					`OP_CALL: begin
						sp_d = sp_q - SP_W'(1);
						stk_we = 1'b1;
						pc_d = call_tgt;
					end
					`OP_SYS: begin
						if (ir_q.mr == 3'h0 && ir_q.mc == `SUB_TABLE) begin
							sp_d = sp_q - SP_W'(1); // save counter, go fetch the table word
							stk_we = 1'b1;
							pm_d = areg_q;
							st_d = S_TABLE;
						end else if (ir_q.mr == 3'h0 && ir_q.mc == `SUB_PUSH) begin
							sp_d = sp_q - SP_W'(1);
							stk_we = 1'b1;
							stk_wdata = areg_q;
						end else if (ir_q.mr == 3'h0 && ir_q.mc == `SUB_POP) begin
							areg_ld = 1'b1;
							sp_d = sp_q + SP_W'(1);
						end else if (ir_q.mr == 3'h0 && ir_q.mc == `SUB_CALL_REG) begin
							sp_d = sp_q - SP_W'(1);
							stk_we = 1'b1;
							pc_d = areg_q;
						end else if (ir_q.mc == `SUB_RET && (ir_q.mr == `RET_PLAIN ||
								ir_q.mr == `RET_SKIP || ir_q.mr == `RET_INT)) begin
							pc_d = stk_rdata;
							sp_d = sp_q + SP_W'(1);
							skip_d = ir_q.mr == `RET_SKIP;
							ctx_rest = ir_q.mr == `RET_INT;
						end
					end
					default: ; // instructions outside this core pass as no-operations
				endcase
			end
			S_READR: begin
				dm_d.addr = ind_addr(dm_rdata);
				if (ir_q.op == `OP_MOV_ST) begin
					dm_d.wdata = mval_q;
					dm_d.we = 1'b1;
					st_d = S_FETCH; // staying here would chase the written address as a new pointer
				end else begin
					st_d = S_READS;
				end
			end
			S_READS: begin
				dm_d.addr = m_addr(ir_q);
				dm_d.wdata = dm_rdata;
				dm_d.we = 1'b1;
				st_d = S_FETCH;
			end
			S_TABLE: begin
				tbuf_ld = 1'b1; // second cycle: take the word and restore the counter
				pc_d = stk_rdata;
				sp_d = sp_q + SP_W'(1);
				st_d = S_FETCH;
			end
			default: st_d = S_FETCH;
		endcase
	end

	// sequencer state, counter and stack pointer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= S_FETCH;
			pc_q <= `PC_RST;
			sp_q <= '1;
		end else if (ce) begin
			st_q <= st_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
		end
	end

	// instruction and operand latches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ir_q <= '0;
			mval_q <= 4'h0;
		end else if (ce) begin
			if (st_q == S_DECODE) ir_q <= pm_word;
			if (st_q == S_READM) mval_q <= dm_rdata;
		end
	end

	// memory ports are registered so the pins never glitch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pm_addr_q <= `PC_RST;
			dm_q <= '0;
		end else if (ce) begin
			pm_addr_q <= pm_d;
			dm_q <= dm_d;
		end
	end

	// skip flag: set by a met condition, consumed by the next fetch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) skip_q <= 1'b0;
		else if (ce) skip_q <= skip_d;
	end

	// compare flag: a software set in the same cycle as the hardware clear wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cflag_q <= 1'(`CTRL_RST >> `CTRL_CFLAG);
		end else if (ce) begin
			if (wr_hit(`OFF_CTRL)) cflag_q <= hwdata[`CTRL_CFLAG];
			else if (cflag_clr) cflag_q <= 1'b0;
		end
	end

	// address register: pop beats a software write in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			areg_q <= `AREG_RST;
		end else if (ce) begin
			if (areg_ld) areg_q <= stk_rdata;
			else if (wr_hit(`OFF_ADDRREG)) areg_q <= hwdata[10:0];
		end
	end

	// data buffer takes the program word in the second table-read cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) tbuf_q <= 16'h0000;
		else if (ce && tbuf_ld) tbuf_q <= pm_data;
	end

	// interrupt: request latched until taken, a new pulse wins over the clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_pend_q <= 1'b0;
			ctx_save_q <= '0;
			ctx_q <= '0;
		end else if (ce) begin
			int_pend_q <= int_entry | (int_pend_q & !int_take);
			if (int_take) ctx_save_q <= ctx_q;
			if (ctx_rest) ctx_q <= ctx_save_q;
			else if (wr_hit(`OFF_CTX)) ctx_q <= hwdata[CTX_W-1:0];
		end
	end

	// software-owned control: run, pointer enable, row pointer, bank and register row
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			ptr_en_q <= 1'b0;
			rowptr_q <= `ROWPTR_RST;
			bank_q <= `BANK_RST;
			grow_q <= `GROW_RST;
		end else if (ce) begin
			if (wr_hit(`OFF_CTRL)) begin
				run_q <= hwdata[`CTRL_RUN];
				ptr_en_q <= hwdata[`CTRL_PTR_EN];
			end
			if (wr_hit(`OFF_ROWPTR)) rowptr_q <= hwdata[6:0];
			if (wr_hit(`OFF_CONFIG)) begin
				bank_q <= hwdata[`CFG_BANK_LSB +: 4];
				grow_q <= hwdata[`CFG_ROW_LSB +: 3];
			end
		end
	end

	// register read mux; unmapped offsets read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		wval = 32'h0000_0000;
		case (haddr[7:0])
			`OFF_CTRL: rd_val = {29'h0, cflag_q, ptr_en_q, run_q};
			`OFF_ROWPTR: rd_val = {25'h0, rowptr_q};
			`OFF_CONFIG: rd_val = {25'h0, grow_q, bank_q};
			`OFF_ADDRREG: rd_val = {21'h0, areg_q};
			`OFF_STATUS: begin
				wval[10:0] = pc_q;
				wval[`STAT_SP_LSB +: SP_W] = sp_q;
				wval[`STAT_SKIP] = skip_q;
				wval[`STAT_INT_PEND] = int_pend_q;
				rd_val = wval;
			end
			`OFF_DBUF: rd_val = {16'h0, tbuf_q};
			`OFF_CTX: begin
				wval[CTX_W-1:0] = ctx_q;
				wval[`CTX_SAVE_LSB +: CTX_W] = ctx_save_q;
				rd_val = wval;
			end
			default: rd_val = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h0) rd_val = 32'h0000_0000;
	end

	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	assign wr_take = hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;

	// bus slave: zero wait states, read data registered at the address phase
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (ce) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_pend_q <= wr_take;
			if (wr_take) wr_addr_q <= haddr[7:0];
			if (rd_take) hrdata_q <= rd_val;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign pm_addr = pm_addr_q;
	assign dm_req = dm_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_bit_true_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_BIT_TRUE |=>
		skip_q == $past(hit_true) && !cflag_q) else $error("bit-test-true skip or compare clear wrong");
	chk_bit_false_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_BIT_FALSE |=>
		skip_q == $past(hit_false)) else $error("bit-test-false skip wrong");
	chk_equal_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_SKIP_EQ |=>
		skip_q == $past(diff_zero) && !dm_q.we) else $error("skip-if-equal wrong");
	chk_nequal_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_SKIP_NE |=>
		skip_q != $past(diff_zero)) else $error("skip-if-not-equal wrong");
	chk_borrow_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_SKIP_GE |=>
		skip_q == !$past(borrow)) else $error("skip-if-greater-equal wrong");
	chk_less_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_SKIP_LT |=>
		skip_q == $past(borrow)) else $error("skip-if-less-than wrong");
	chk_ind_store: assert property (ce && st_q == S_READR && ir_q.op == `OP_MOV_ST |=>
		dm_q.we && dm_q.wdata == $past(mval_q)) else $error("indirect store write missing");
	chk_ind_load: assert property (ce && st_q == S_READS |=> dm_q.we && st_q == S_FETCH)
		else $error("indirect load write missing");
	chk_table_two: assert property (ce && st_q == S_READM && ir_q.op == `OP_SYS && ir_q.mr == 3'h0 &&
		ir_q.mc == `SUB_TABLE |=> st_q == S_TABLE && sp_q == $past(sp_q) - SP_W'(1))
		else $error("table read did not enter its second cycle");
	chk_table_restore: assert property (ce && st_q == S_TABLE |=> pc_q == $past(stk_rdata) &&
		tbuf_q == $past(pm_data)) else $error("table read restore wrong");
	chk_pop_load: assert property (ce && areg_ld |=> areg_q == $past(stk_rdata) &&
		sp_q == $past(sp_q) + SP_W'(1)) else $error("pop wrong");
	chk_call_target: assert property (ce && st_q == S_READM && ir_q.op == `OP_CALL |=>
		pc_q == {1'b0, $past(ir_q[9:0])} && !pc_q[10]) else $error("call target wrong");
	chk_ret_skip: assert property (ce && st_q == S_READM && ir_q.op == `OP_SYS &&
		ir_q.mc == `SUB_RET && ir_q.mr == `RET_SKIP |=> skip_q) else $error("return-and-skip lost skip");
	chk_nop_skip: assert property (ce && st_q == S_DECODE && skip_q |=> st_q == S_FETCH &&
		!dm_q.we && !skip_q) else $error("skipped instruction not a no-operation");

	cov_skip_taken: cover property (ce && st_q == S_DECODE && skip_q);
	cov_table_read: cover property (ce && st_q == S_TABLE);
	cov_ptr_store: cover property (ce && st_q == S_READR && ptr_en_q && ir_q.op == `OP_MOV_ST);
	cov_int_return: cover property (ce && ctx_rest);
endmodule

// ### mem_model.sv
// program and data memory model facing the decode core
`timescale 1ns/1ps
module mem_model (
	input wire logic ref_clk,
	input wire logic [10:0] pm_addr,
	output logic [15:0] pm_data,
	input wire cpu_pkg::dm_req_t dm_req,
	output logic [3:0] dm_rdata
);
	import cpu_pkg::*;
	logic [15:0] prog [0:2047];
	logic [3:0] dm [0:2047];
	// both reads are combinational, since the core samples them in the cycle the address stands
	assign pm_data = prog[pm_addr];
	assign dm_rdata = dm[dm_req.addr];
	// a write lands at the edge that closes the one-cycle strobe
	always @(posedge ref_clk) begin
		if (dm_req.we === 1'b1) begin
			dm[dm_req.addr] <= dm_req.wdata;
		end
	end
	// the bench clears both arrays only while the core is held in reset
	task automatic clear_all();
		for (int i = 0; i < 2048; i++) begin
			prog[i] = 16'h0000;
			dm[i] = 4'h0;
		end
	endtask
endmodule

// ### testbench.sv
// self-checking bench for the decode core: skips, indirect moves, table read, stack, calls, returns
`timescale 1ns/1ps
`include "cpu_defs_regs.svh"
module testbench;
	import cpu_pkg::*;
	localparam logic [10:0] VEC = 11'h040;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic int_entry = 1'b0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [10:0] pm_addr;
	logic [15:0] pm_data;
	dm_req_t dm_req;
	logic [3:0] dm_rdata;
	int err_count = 0;
	int check_count = 0;
	logic [4:0] ops [6] = '{5'h1E, 5'h1F, 5'h09, 5'h0B, 5'h19, 5'h1B};
	logic [4:0] op;
	logic [3:0] bank, mv, nv, col, col2, sv, lv;
	logic [7:0] c1;
	logic pe;
	logic [10:0] dst, tgt, tg2;
	logic [31:0] rd;

	always #50 ref_clk = ~ref_clk;

	// hready is the single slave's own hreadyout; ce stays on so nothing freezes
	decode_core #(.SP_W(3), .CTX_W(8), .INT_VECTOR(VEC)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_entry(int_entry),
		.pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req), .dm_rdata(dm_rdata));
	mem_model i_mem (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
		.dm_rdata(dm_rdata));

	// expected skip decision, worked out from the masks and a 5-bit difference
	function automatic logic skip_exp(input logic [4:0] o, input logic [3:0] m, input logic [3:0] n);
		logic [4:0] d;
		d = {1'b0, m} - {1'b0, n};
		case (o)
			5'h1E: return (m & n) == n;
			5'h1F: return (m & n) == 4'h0;
			5'h09: return d[3:0] == 4'h0;
			5'h0B: return d[3:0] != 4'h0;
			5'h19: return !d[4];
			default: return d[4];
		endcase
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one single word transfer; the request holds until hready is seen high at an edge
	task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rdat);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, off};
		hwrite <= wr;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rdat = hrdata;
		check({31'h0, hresp}, 32'h0, "response");
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, off, d, x);
	endtask

	task automatic rdc(input logic [7:0] off, input logic [31:0] exp, input string what);
		logic [31:0] x;
		bus(1'b0, off, 32'h0, x);
		check(x, exp, what);
	endtask

	// short reset between tests returns pc, sp and flags to known values
	task automatic restart();
		rst <= 1'b1;
		i_mem.clear_all();
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog sized well above the roughly 1400 cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		void'($urandom(38));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check({31'h0, hreadyout}, 32'h1, "ready after reset");
		// reset values and an unmapped place that ignores writes
		wr(8'h1C, 32'hFFFFFFFF);
		rdc(8'h1C, 32'h0, "unmapped");
		rdc(`OFF_CTRL, 32'h0, "ctrl reset");
		rdc(`OFF_STATUS, 32'h00070000, "status reset");
		rdc(`OFF_ADDRREG, 32'h0, "addr reset");
		$display("test reset done");
		// compare or bit test, then an indirect store it may skip, then an indirect load
		for (int i = 0; i < 24; i++) begin
			op = ops[i % 6];
			bank = 4'($urandom);
			mv = 4'($urandom);
			nv = (i < 6) ? mv : 4'($urandom);
			col = 4'($urandom_range(15, 2));
			col2 = col ^ 4'h1;
			sv = 4'($urandom_range(15, 1));
			lv = 4'($urandom);
			pe = 1'($urandom);
			restart();
			i_mem.dm[{bank, 3'h1, 4'h0}] = mv;
			i_mem.dm[{bank, 3'h0, 4'h1}] = col;
			i_mem.dm[{bank, 3'h0, 4'h2}] = col2;
			i_mem.dm[{bank, 3'h2, 4'h0}] = sv;
			i_mem.dm[pe ? {bank, 3'h5, col2} : {bank, 3'h3, col2}] = lv;
			i_mem.dm[pe ? {bank, 3'h3, col2} : {bank, 3'h5, col2}] = ~lv;
			i_mem.prog[0] = {op, 3'h1, 4'h0, nv};
			i_mem.prog[1] = {5'h0A, 3'h2, 4'h0, 4'h1};
			i_mem.prog[2] = {5'h1A, 3'h3, 4'h0, 4'h2};
			wr(`OFF_CONFIG, 32'(bank));
			wr(`OFF_ROWPTR, 32'({bank, 3'h5}));
			wr(`OFF_CTRL, {29'h0, 1'b1, pe, 1'b1});
			repeat (40) @(posedge ref_clk);
			dst = pe ? {bank, 3'h5, col} : {bank, 3'h2, col};
			check(32'(i_mem.dm[dst]), skip_exp(op, mv, nv) ? 32'h0 : 32'(sv), "skip");
			check(32'(i_mem.dm[{bank, 3'h1, 4'h0}]), 32'(mv), "operand kept");
			check(32'(i_mem.dm[{bank, 3'h3, 4'h0}]), 32'(lv), "load");
			rdc(`OFF_CTRL, {29'h0, op[4:1] != 4'hF, pe, 1'b1}, "compare flag");
		end
		$display("test skip and move done");
		// table read, indirect call, pop, push, return and skip, immediate call, plain return
		restart();
		tgt = 11'h100 + 11'($urandom_range(255));
		tg2 = 11'h200 + 11'($urandom_range(255));
		i_mem.prog[0] = 16'h3810;
		i_mem.prog[1] = 16'h3850;
		i_mem.prog[2] = {5'h0A, 3'h2, 4'h0, 4'h1};
		i_mem.prog[3] = {5'h0A, 3'h2, 4'h1, 4'h2};
		i_mem.prog[4] = {5'h1C, 1'b1, tg2[9:0]};
		i_mem.prog[5] = {5'h0A, 3'h2, 4'h2, 4'h5};
		i_mem.prog[tgt] = 16'h38C0;
		i_mem.prog[tgt + 11'h1] = 16'h38D0;
		i_mem.prog[tgt + 11'h2] = 16'h39E0;
		i_mem.prog[tg2] = 16'h38E0;
		i_mem.dm[11'h001] = 4'h3;
		i_mem.dm[11'h002] = 4'h4;
		i_mem.dm[11'h005] = 4'h7;
		i_mem.dm[11'h020] = 4'h9;
		i_mem.dm[11'h021] = 4'h6;
		i_mem.dm[11'h022] = 4'hA;
		wr(`OFF_ADDRREG, 32'(tgt));
		wr(`OFF_CTRL, 32'h1);
		repeat (80) @(posedge ref_clk);
		check(32'(i_mem.dm[11'h023]), 32'h0, "skipped after return");
		check(32'(i_mem.dm[11'h024]), 32'h6, "after return");
		check(32'(i_mem.dm[11'h027]), 32'hA, "after call");
		rdc(`OFF_DBUF, 32'h38C0, "table word");
		rdc(`OFF_ADDRREG, 32'h2, "popped");
		bus(1'b0, `OFF_STATUS, 32'h0, rd);
		check(32'(rd[18:16]), 32'h7, "stack balanced");
		$display("test call and return done");
		// interrupt entry saves context, software changes it, interrupt return restores it
		restart();
		c1 = 8'($urandom);
		i_mem.prog[VEC + 11'h10] = 16'h3CE0;
		wr(`OFF_CTX, 32'(c1));
		wr(`OFF_CTRL, 32'h1);
		int_entry <= 1'b1;
		@(posedge ref_clk);
		int_entry <= 1'b0;
		repeat (5) @(posedge ref_clk);
		wr(`OFF_CTX, 32'(~c1));
		rdc(`OFF_CTX, {16'h0, c1, ~c1}, "context saved");
		repeat (60) @(posedge ref_clk);
		rdc(`OFF_CTX, {16'h0, c1, c1}, "context restored");
		bus(1'b0, `OFF_STATUS, 32'h0, rd);
		check(32'(rd[18:16]), 32'h7, "stack after interrupt return");
		$display("test interrupt return done");
		report_and_stop();
	end
endmodule
